//--- bench/bldc_commutation_mode_control_tb_top.sv
`timescale 1ns/1ns
module bldc_commutation_mode_control_tb_top;
	import bldc_pkg::*;

	localparam int REFRESH  = 50;
	localparam int FWD_STOP = 200;

	logic        clk = 1'b0, rstn = 1'b0, hall_u, hall_v, hall_w;
	logic        spin = 1'b0, fwd = 1'b1, drive_style_sel = 1'b0, lead_kill = 1'b0;
	logic [7:0]  gap = 8'h32, speed_level = 8'h00, duty;
	logic [4:0]  lead_angle_input = 5'h1f, lead_step;
	logic [2:0]  wave_high = 3'h0, wave_low = 3'h0, high_on, low_on;
	speed_band_e speed_band = BAND_OFF;
	drive_mode_e drive_mode;
	logic        gate_block, refresh_active, rotor_forward, rotor_running;
	int          err_total = 0, n_checks = 0;

	bldc_commutation_mode_control #(
		.FWD_STOP(FWD_STOP),
		.REV_STOP(40),
		.REFRESH (REFRESH)
	) bldc_commutation_mode_control_inst (
		.clk, .rstn, .hall_u, .hall_v, .hall_w, .drive_style_sel, .lead_angle_input,
		.speed_band, .speed_level, .lead_kill, .wave_high, .wave_low, .gate_block,
		.drive_mode, .lead_step, .duty, .high_on, .low_on, .refresh_active,
		.rotor_forward, .rotor_running
	);

	hall_model hall_model_inst (.clk, .spin, .fwd, .gap, .hall_u, .hall_v, .hall_w);

	always #5 clk = ~clk;

	task automatic check(input logic ok, input string what);
		n_checks++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	// Counts cycles in one carrier period with exactly want low sides on.
	task automatic count_low(input int want, output int on, output int rises);
		logic prev;
		on = 0;
		rises = 0;
		prev = |low_on;
		repeat (252)
		begin
			@(negedge clk);
			on += ($countones(low_on) == want);
			rises += (|low_on && !prev);
			prev = |low_on;
		end
	endtask : count_low

	task automatic t_refresh();
		int on;
		int rises;
		speed_band = BAND_REFRESH;
		cyc(300);
		count_low(3, on, rises);
		check(on == int'(LOW_ON_CYCLES), "refresh pulse width");
		check(rises == 1, "refresh pulse rate");
	endtask : t_refresh

	task automatic t_start();
		int on;
		int rises;
		int hi;
		speed_band = BAND_OFF;
		cyc(5);
		check(gate_block === 1'b1 && high_on === 3'h0 && low_on === 3'h0, "off gates");
		speed_band = BAND_NORMAL;
		cyc(3);
		check(refresh_active === 1'b1, "no refresh from stop");
		cyc(REFRESH + 300);
		check(refresh_active === 1'b0, "refresh too long");
		check(drive_mode === MODE_SQUARE && lead_step === 5'h00, "slow not square");
		check(duty === DUTY_MIN, "minimum duty");
		count_low(2, on, rises);
		check(on == int'(LOW_ON_CYCLES), "square low forcing");
		hi = 0;
		repeat (CARRIER_PERIOD)
		begin
			@(negedge clk);
			hi += (high_on == 3'h1);
		end
		check(hi >= int'(DUTY_MIN) - 1 && hi <= int'(DUTY_MIN) + 1, "square pwm width");
	endtask : t_start

	task automatic t_run();
		int slope;
		slope = int'(DUTY_MIN) + 128 * int'(DUTY_MAX_WIDE - DUTY_MIN) / 256;
		spin = 1'b1;
		wave_high = 3'h5;
		wave_low = 3'h2;
		speed_level = LEVEL_FULL;
		cyc(600);
		check(rotor_forward === 1'b1 && rotor_running === 1'b1, "no forward run");
		check(drive_mode === MODE_SINE && lead_step === 5'h1f, "sine lead");
		check(high_on === 3'h5 && low_on === 3'h2, "sine pass");
		check(duty === DUTY_MAX_SINE, "sine clamp");
		lead_kill = 1'b1;
		cyc(4);
		check(lead_step === 5'h00, "lead not killed");
		lead_kill = 1'b0;
		drive_style_sel = 1'b1;
		speed_level = 8'h80;
		cyc(6);
		check(drive_mode === MODE_WIDE && lead_step === 5'h0f, "wide lead");
		check(duty === 8'(slope), "duty slope");
		speed_level = LEVEL_FULL;
		cyc(4);
		check(duty === DUTY_MAX_WIDE, "wide clamp");
		speed_band = BAND_OFF;
		cyc(4);
		speed_band = BAND_NORMAL;
		cyc(2);
		check(refresh_active === 1'b0 && gate_block === 1'b0, "running start slow");
	endtask : t_run

	task automatic t_test();
		speed_band = BAND_TEST;
		cyc(4);
		check(drive_mode === MODE_WIDE && lead_step === 5'h00, "test wide");
		drive_style_sel = 1'b0;
		cyc(6);
		check(drive_mode === MODE_SINE && lead_step === 5'h00, "test sine");
		fwd = 1'b0;
		gap = 8'h14;
		cyc(300);
		check(rotor_forward === 1'b0 && rotor_running === 1'b1, "no reverse run");
		check(drive_mode === MODE_SQUARE && lead_step === 5'h00, "test reverse");
		speed_band = BAND_NORMAL;
		cyc(4);
		check(drive_mode === MODE_SQUARE, "normal reverse");
	endtask : t_test

	task automatic t_stop();
		fwd = 1'b1;
		gap = 8'h32;
		cyc(600);
		spin = 1'b0;
		cyc(FWD_STOP / 2);
		check(rotor_running === 1'b1, "stop seen early");
		cyc(FWD_STOP * 3 / 4);
		check(rotor_running === 1'b0 && drive_mode === MODE_SQUARE, "stop missed");
	endtask : t_stop

	initial
	begin
		cyc(20);
		rstn = 1'b1;
		cyc(1);
		t_refresh();
		t_start();
		t_run();
		t_test();
		t_stop();
		conclude();
	end

	initial
	begin
		#200_000;
		err_total++;
		$display("[ERR] %0t watchdog expired", $time);
		conclude();
	end
endmodule : bldc_commutation_mode_control_tb_top

bind bldc_commutation_mode_control bldc_mode_sva #(
	.REFRESH(REFRESH)
) bldc_mode_sva_inst (
	.clk, .rstn, .speed_band, .speed_level, .wave_high, .wave_low, .gate_block,
	.drive_mode, .lead_step, .duty, .high_on, .low_on, .refresh_active, .rotor_running
);

//--- bench/bldc_mode_sva.sv
`timescale 1ns/1ns
module bldc_mode_sva #(
	parameter int REFRESH = bldc_pkg::REFRESH_CYCLES
)(
	input wire logic                  clk,
	input wire logic                  rstn,
	input wire bldc_pkg::speed_band_e speed_band,
	input wire logic            [7:0] speed_level,
	input wire logic            [2:0] wave_high,
	input wire logic            [2:0] wave_low,
	input wire logic                  gate_block,
	input wire bldc_pkg::drive_mode_e drive_mode,
	input wire logic            [4:0] lead_step,
	input wire logic            [7:0] duty,
	input wire logic            [2:0] high_on,
	input wire logic            [2:0] low_on,
	input wire logic                  refresh_active,
	input wire logic                  rotor_running
);
	import bldc_pkg::*;

	logic        [7:0]  lo_run;
	logic        [4:0]  age;
	logic        [17:0] ref_run;
	speed_band_e        band_q;

	// Run lengths are counted here because a repetition of 18 or more would not unroll.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			lo_run  <= 8'h00;
			age     <= 5'h00;
			ref_run <= 18'h0;
			band_q  <= BAND_OFF;
		end
		else
		begin
			lo_run  <= (|low_on) ? lo_run + 8'h01 : 8'h00;
			age     <= (speed_band != band_q) ? 5'h00 : age + {4'h0, ~&age};
			ref_run <= refresh_active ? ref_run + 18'h1 : 18'h0;
			band_q  <= speed_band;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence off_held;
		speed_band == BAND_OFF ##1 speed_band == BAND_OFF;
	endsequence

	sequence drive_req;
		speed_band == BAND_NORMAL && $past(speed_band) == BAND_OFF;
	endsequence

	chk_off_gates: assert property (
		off_held |-> gate_block && high_on == 3'h0 && low_on == 3'h0)
		else $error("gates live in off band");
	chk_low_width: assert property (
		$fell(|low_on) && speed_band == BAND_REFRESH && age == 5'h1f
		|-> lo_run == {3'h0, LOW_ON_CYCLES}) else $error("low pulse width wrong");
	chk_refresh_len: assert property (
		$fell(refresh_active) && speed_band == BAND_NORMAL && age == 5'h1f
		|-> ref_run >= REFRESH && ref_run <= REFRESH + 1) else $error("refresh length wrong");
	chk_stop_refresh: assert property (
		drive_req and !rotor_running |=> refresh_active) else $error("no refresh from stop");
	chk_run_direct: assert property (
		drive_req and rotor_running |=> !refresh_active && !gate_block)
		else $error("running start delayed");
	chk_slow_square: assert property (
		(speed_band == BAND_NORMAL && !rotor_running) [*3] |-> drive_mode == MODE_SQUARE)
		else $error("slow rotor not square");
	chk_square_lead: assert property (
		drive_mode == MODE_SQUARE |-> lead_step == 5'h00) else $error("square with lead");
	chk_duty_top: assert property (
		(speed_level == LEVEL_FULL && speed_band == BAND_NORMAL && !refresh_active) [*3]
		##0 drive_mode == MODE_SINE |-> duty == DUTY_MAX_SINE) else $error("sine clamp wrong");
	chk_wave_pass: assert property (
		$past(speed_band) == BAND_NORMAL && drive_mode != MODE_SQUARE && !refresh_active
		&& !gate_block |-> high_on == $past(wave_high) && low_on == $past(wave_low))
		else $error("wave not passed");
endmodule : bldc_mode_sva

//--- bench/hall_model.sv
`timescale 1ns/1ns
module hall_model (
	input  wire logic       clk,
	input  wire logic       spin,
	input  wire logic       fwd,
	input  wire logic [7:0] gap,
	output logic            hall_u,
	output logic            hall_v,
	output logic            hall_w
);
	logic [2:0] pos = 3'h0;
	logic [7:0] cnt = 8'h00;

	// A standing rotor keeps its sensor levels, so the code holds between steps.
	always_comb
	begin
		case (pos)
			3'h0:    {hall_w, hall_v, hall_u} = 3'h1;
			3'h1:    {hall_w, hall_v, hall_u} = 3'h3;
			3'h2:    {hall_w, hall_v, hall_u} = 3'h2;
			3'h3:    {hall_w, hall_v, hall_u} = 3'h6;
			3'h4:    {hall_w, hall_v, hall_u} = 3'h4;
			default: {hall_w, hall_v, hall_u} = 3'h5;
		endcase
	end

	always @(negedge clk)
	begin
		if (spin)
		begin
			cnt <= (cnt + 8'h01 >= gap) ? 8'h00 : cnt + 8'h01;
			if (cnt + 8'h01 >= gap)
				pos <= fwd ? ((pos == 3'h5) ? 3'h0 : pos + 3'h1)
				           : ((pos == 3'h0) ? 3'h5 : pos - 3'h1);
		end
	end
endmodule : hall_model

//--- rtl/bldc_commutation_mode_control.sv
`timescale 1ns/1ns
module bldc_commutation_mode_control
	import bldc_pkg::*;
#(
	parameter int FWD_STOP = FWD_STOP_CYCLES,
	parameter int REV_STOP = REV_STOP_CYCLES,
	parameter int REFRESH  = REFRESH_CYCLES
)(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic                 hall_u,
	input  wire logic                 hall_v,
	input  wire logic                 hall_w,
	input  wire logic                 drive_style_sel,
	input  wire logic           [4:0] lead_angle_input,
	input  wire bldc_pkg::speed_band_e speed_band,
	input  wire logic           [7:0] speed_level,
	input  wire logic                 lead_kill,
	input  wire logic           [2:0] wave_high,
	input  wire logic           [2:0] wave_low,
	output logic                      gate_block,
	output bldc_pkg::drive_mode_e     drive_mode,
	output logic                [4:0] lead_step,
	output logic                [7:0] duty,
	output logic                [2:0] high_on,
	output logic                [2:0] low_on,
	output logic                      refresh_active,
	output logic                      rotor_forward,
	output logic                      rotor_running
);

	import bldc_pkg::*;

	typedef enum logic [1:0] {
		CS_IDLE   = 2'b00,
		CS_CHARGE = 2'b01,
		CS_PRE    = 2'b10,
		CS_DRIVE  = 2'b11
	} ctl_state_e;

	typedef struct packed {
		logic        ss_s1;
		logic        ss_s2;
		logic [4:0]  la_s1;
		logic [4:0]  la_s2;
		logic [4:0]  la_s3;
		logic [4:0]  la_keep;
		ctl_state_e  state;
		logic [31:0] ref_cnt;
		logic [4:0]  pulse_cnt;
		drive_mode_e mode;
		logic [4:0]  lead;
		logic [7:0]  duty;
		logic        block;
		logic [2:0]  high;
		logic [2:0]  low;
		logic        refresh;
	} ctl_s;

	// Square 120 degree pattern: {high phases, low phases} for a sector.
	function automatic logic [5:0] square_pattern(input logic [2:0] sec);
		case (sec)
			3'h0:    square_pattern = {3'b001, 3'b010};
			3'h1:    square_pattern = {3'b001, 3'b100};
			3'h2:    square_pattern = {3'b010, 3'b100};
			3'h3:    square_pattern = {3'b010, 3'b001};
			3'h4:    square_pattern = {3'b100, 3'b001};
			3'h5:    square_pattern = {3'b100, 3'b010};
			default: square_pattern = 6'h00;
		endcase
	endfunction : square_pattern

	// Linear ramp from the minimum to the style's maximum, clamped at full level.
	function automatic logic [7:0] duty_of(input logic [7:0] level, input logic wide);
		logic [7:0]  top;
		logic [15:0] scaled;
		top    = wide ? DUTY_MAX_WIDE : DUTY_MAX_SINE;
		scaled = level * (top - DUTY_MIN);
		if (level == LEVEL_FULL)
		begin
			duty_of = top;
		end
		else
		begin
			duty_of = DUTY_MIN + scaled[15:8];
		end
	endfunction : duty_of

	ctl_s        state_reg;
	ctl_s        state_next;
	logic [6:0]  tri_level;
	logic        period_start;
	logic [2:0]  sector;
	logic        forward;
	logic        running;
	drive_mode_e style;
	logic        force_win;
	logic        pwm_on;
	logic [5:0]  pattern;
	logic        want_drive;

	carrier_gen u_carrier (
		.clk          (clk),
		.rstn         (rstn),
		.tri_level    (tri_level),
		.period_start (period_start)
	);

	hall_tracker #(
		.FWD_STOP (FWD_STOP),
		.REV_STOP (REV_STOP)
	) u_hall (
		.clk     (clk),
		.rstn    (rstn),
		.hall_u  (hall_u),
		.hall_v  (hall_v),
		.hall_w  (hall_w),
		.sector  (sector),
		.forward (forward),
		.running (running)
	);

	always_comb
	begin
		state_next       = state_reg;
		state_next.ss_s1 = drive_style_sel;
		state_next.ss_s2 = state_reg.ss_s1;
		state_next.la_s1 = lead_angle_input;
		state_next.la_s2 = state_reg.la_s1;
		state_next.la_s3 = state_reg.la_s2;
		// The converter code can be caught mid-change, so only a code seen twice is used.
		if (state_reg.la_s2 == state_reg.la_s3)
		begin
			state_next.la_keep = state_reg.la_s2;
		end

		style      = state_reg.ss_s2 ? MODE_WIDE : MODE_SINE;
		want_drive = (speed_band == BAND_NORMAL) || (speed_band == BAND_TEST);

		// Low-side window opens at each carrier start and lasts 18 cycles.
		if (period_start)
		begin
			state_next.pulse_cnt = LOW_ON_CYCLES;
		end
		else if (state_reg.pulse_cnt != 5'h00)
		begin
			state_next.pulse_cnt = state_reg.pulse_cnt - 5'h01;
		end
		force_win = (state_reg.pulse_cnt != 5'h00);

		case (state_reg.state)
			CS_IDLE:
			begin
				if (speed_band == BAND_REFRESH)
				begin
					state_next.state = CS_CHARGE;
				end
				else if (want_drive && running)
				begin
					state_next.state = CS_DRIVE;
				end
				else if (want_drive)
				begin
					state_next.state   = CS_PRE;
					state_next.ref_cnt = 32'(REFRESH - 1);
				end
			end
			CS_CHARGE:
			begin
				if (speed_band == BAND_OFF)
				begin
					state_next.state = CS_IDLE;
				end
				else if (want_drive && running)
				begin
					state_next.state = CS_DRIVE;
				end
				else if (want_drive)
				begin
					state_next.state   = CS_PRE;
					state_next.ref_cnt = 32'(REFRESH - 1);
				end
			end
			CS_PRE:
			begin
				if (speed_band == BAND_OFF)
				begin
					state_next.state = CS_IDLE;
				end
				else if (speed_band == BAND_REFRESH)
				begin
					state_next.state = CS_CHARGE;
				end
				else if (state_reg.ref_cnt == 32'h0)
				begin
					state_next.state = CS_DRIVE;
				end
				else
				begin
					state_next.ref_cnt = state_reg.ref_cnt - 32'h1;
				end
			end
			CS_DRIVE:
			begin
				if (speed_band == BAND_OFF)
				begin
					state_next.state = CS_IDLE;
				end
				else if (speed_band == BAND_REFRESH)
				begin
					state_next.state = CS_CHARGE;
				end
			end
			default:
			begin
				state_next.state = CS_IDLE;
			end
		endcase

		// Test band skips the low-speed check but still falls back on reverse.
		if (speed_band == BAND_TEST)
		begin
			state_next.mode = forward ? style : MODE_SQUARE;
		end
		else if (running && forward)
		begin
			state_next.mode = style;
		end
		else
		begin
			state_next.mode = MODE_SQUARE;
		end

		if (state_next.mode == MODE_SQUARE)
		begin
			state_next.lead = 5'h00;
		end
		else if (speed_band == BAND_TEST)
		begin
			state_next.lead = 5'h00;
		end
		else if (lead_kill)
		begin
			state_next.lead = 5'h00;
		end
		else if (style == MODE_WIDE)
		begin
			state_next.lead = {1'b0, state_reg.la_keep[4:1]};
		end
		else
		begin
			state_next.lead = state_reg.la_keep;
		end

		// The shown level already saturates at the 5.4 V point upstream.
		state_next.duty = duty_of(speed_level, state_reg.ss_s2);

		pwm_on  = ({1'b0, tri_level} << 1) < {1'b0, state_reg.duty};
		pattern = square_pattern(sector);

		state_next.block   = 1'b0;
		state_next.high    = 3'h0;
		state_next.low     = 3'h0;
		state_next.refresh = 1'b0;
		case (state_next.state)
			CS_IDLE:
			begin
				state_next.block = 1'b1;
			end
			CS_CHARGE:
			begin
				state_next.low = {3{force_win}};
			end
			CS_PRE:
			begin
				state_next.low     = {3{force_win}};
				state_next.refresh = 1'b1;
			end
			CS_DRIVE:
			begin
				if (state_next.mode == MODE_SQUARE)
				begin
					state_next.high = pattern[5:3] & {3{pwm_on}};
					// Idle phases get the low-side pulse so their gate supply stays up.
					state_next.low  = pattern[2:0] | ({3{force_win}} & ~pattern[5:3]);
				end
				else
				begin
					state_next.high = wave_high;
					state_next.low  = wave_low;
				end
			end
			default:
			begin
				state_next.block = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg       <= '0;
			state_reg.state <= CS_IDLE;
			state_reg.block <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign gate_block     = state_reg.block;
	assign drive_mode     = state_reg.mode;
	assign lead_step      = state_reg.lead;
	assign duty           = state_reg.duty;
	assign high_on        = state_reg.high;
	assign low_on         = state_reg.low;
	assign refresh_active = state_reg.refresh;
	assign rotor_forward  = forward;
	assign rotor_running  = running;

endmodule : bldc_commutation_mode_control

//--- rtl/bldc_pkg.sv
package bldc_pkg;

	// Carrier and low-side pulse timing in oscillator cycles.
	localparam int         CARRIER_PERIOD = 252;
	localparam int         CARRIER_HALF   = 126;
	localparam logic [4:0] LOW_ON_CYCLES  = 5'h12;

	// Clock rate and the refresh time before the first drive from standstill.
	localparam int CLK_HZ          = 100_000_000;
	localparam int REFRESH_TIME_NS = 1_500_000;
	localparam int REFRESH_CYCLES  = REFRESH_TIME_NS / 1000 * (CLK_HZ / 1_000_000);

	// Stop thresholds are oscillator counts, so they scale with the oscillator rate.
	localparam int REF_OSC_HZ      = 5_000_000;
	localparam int HALL_EDGES      = 6;
	localparam int FWD_STOP_HZ     = 1;
	localparam int REV_STOP_HZ     = 5;
	localparam int FWD_STOP_CYCLES = REF_OSC_HZ / (HALL_EDGES * FWD_STOP_HZ);
	localparam int REV_STOP_CYCLES = REF_OSC_HZ / (HALL_EDGES * REV_STOP_HZ);

	// On-duty in carrier counts out of 252.
	localparam logic [7:0] DUTY_MIN      = 8'h06;
	localparam logic [7:0] DUTY_MAX_SINE = 8'he8;
	localparam logic [7:0] DUTY_MAX_WIDE = 8'hef;
	localparam logic [7:0] LEVEL_FULL    = 8'hff;

	localparam logic [2:0] SECTOR_NONE = 3'h7;
	localparam logic [2:0] SECTOR_LAST = 3'h5;

	typedef enum logic [1:0] {
		BAND_OFF     = 2'b00,
		BAND_REFRESH = 2'b01,
		BAND_NORMAL  = 2'b10,
		BAND_TEST    = 2'b11
	} speed_band_e;

	typedef enum logic [1:0] {
		MODE_SQUARE = 2'b00,
		MODE_SINE   = 2'b01,
		MODE_WIDE   = 2'b10
	} drive_mode_e;

	// Hall code {w,v,u} to sector 0..5; all-high or all-low is no sector.
	function automatic logic [2:0] sector_of(input logic [2:0] code);
		case (code)
			3'h1:    sector_of = 3'h0;
			3'h3:    sector_of = 3'h1;
			3'h2:    sector_of = 3'h2;
			3'h6:    sector_of = 3'h3;
			3'h4:    sector_of = 3'h4;
			3'h5:    sector_of = 3'h5;
			default: sector_of = SECTOR_NONE;
		endcase
	endfunction : sector_of

endpackage : bldc_pkg

//--- rtl/carrier_gen.sv
`timescale 1ns/1ns
module carrier_gen
	import bldc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	output logic      [6:0] tri_level,
	output logic            period_start
);

	typedef struct packed {
		logic [7:0] phase;
		logic [6:0] level;
		logic       start;
	} carrier_s;

	carrier_s state_reg;
	carrier_s state_next;

	always_comb
	begin
		state_next = state_reg;
		if (state_reg.phase == 8'(CARRIER_PERIOD - 1))
		begin
			state_next.phase = 8'h00;
		end
		else
		begin
			state_next.phase = state_reg.phase + 8'h01;
		end
		// Up for the first half, down for the second, peak at 126.
		if (state_next.phase < 8'(CARRIER_HALF))
		begin
			state_next.level = state_next.phase[6:0];
		end
		else
		begin
			state_next.level = 7'(CARRIER_PERIOD - int'(state_next.phase));
		end
		state_next.start = (state_next.phase == 8'h00);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign tri_level    = state_reg.level;
	assign period_start = state_reg.start;

endmodule : carrier_gen

//--- rtl/hall_tracker.sv
`timescale 1ns/1ns
module hall_tracker
	import bldc_pkg::*;
#(
	parameter int FWD_STOP = FWD_STOP_CYCLES,
	parameter int REV_STOP = REV_STOP_CYCLES
)(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       hall_u,
	input  wire logic       hall_v,
	input  wire logic       hall_w,
	output logic      [2:0] sector,
	output logic            forward,
	output logic            running
);

	typedef struct packed {
		logic [2:0]  s1;
		logic [2:0]  s2;
		logic [2:0]  prev;
		logic [31:0] cnt;
		logic        fwd;
		logic        run;
	} track_s;

	track_s      state_reg;
	track_s      state_next;
	logic [2:0]  sec_now;
	logic [2:0]  sec_succ;
	logic [31:0] limit;

	always_comb
	begin
		state_next    = state_reg;
		state_next.s1 = {hall_w, hall_v, hall_u};
		state_next.s2 = state_reg.s1;
		sec_now       = sector_of(state_reg.s2);
		sec_succ      = (state_reg.prev == SECTOR_LAST) ? 3'h0 : state_reg.prev + 3'h1;
		limit         = state_reg.fwd ? 32'(FWD_STOP) : 32'(REV_STOP);
		if (sec_now != SECTOR_NONE && sec_now != state_reg.prev)
		begin
			if (state_reg.prev != SECTOR_NONE)
			begin
				// A short interval in a known order means the rotor is turning.
				state_next.fwd = (sec_now == sec_succ);
				state_next.run = state_reg.cnt < (state_next.fwd ? 32'(FWD_STOP) : 32'(REV_STOP));
			end
			state_next.prev = sec_now;
			state_next.cnt  = 32'h0;
		end
		else
		begin
			if (state_reg.cnt >= limit)
			begin
				state_next.run = 1'b0;
			end
			else
			begin
				state_next.cnt = state_reg.cnt + 32'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg      <= '0;
			state_reg.prev <= SECTOR_NONE;
			state_reg.fwd  <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign sector  = state_reg.prev;
	assign forward = state_reg.fwd;
	assign running = state_reg.run;

endmodule : hall_tracker
